// [hdl/cca_pkg.sv]
package cca_pkg;

  // timebase figures, kept as printed, and cycle counts derived from them
  localparam longint CLK_HZ             = 100_000_000;
  localparam longint TEMP_PERIOD_MS     = 440;
  localparam longint SAMPLE_RATE_100HZ  = 186;        // 18.6 kHz
  localparam longint CONV_PERIOD_US     = 3_515_000;  // 3.515 s
  localparam longint TEMP_CYC   = CLK_HZ * TEMP_PERIOD_MS / 1000;
  localparam longint SAMPLE_CYC = CLK_HZ / (SAMPLE_RATE_100HZ * 100);
  localparam longint CONV_CYC   = CLK_HZ * CONV_PERIOD_US / 1_000_000;

  // conversion bookkeeping
  localparam int             AVG_DEPTH    = 8;
  localparam int             AVG_SHIFT    = 3;
  localparam logic [9:0]     OFFSET_SLOT  = 10'h03FF; // every 1024th
  localparam logic [7:0]     BACKUP_EVERY = 8'h10;    // conversions
  localparam int             GAIN_FRAC    = 10;
  localparam int             TC_SHIFT     = 15;       // 30.5 ppm step
  localparam int             FRAC_W       = 12;

  // limits and thresholds
  localparam logic [15:0]    CUR_MAX      = 16'h7FFF;
  localparam logic [15:0]    CUR_MIN      = 16'h8000;
  localparam logic [15:0]    CHG_MIN      = 16'h0040; // 100 uV
  localparam logic [15:0]    TC_REF_HALF  = 16'h0032; // 25 C in 0.5 C
  localparam logic [27:0]    ACC_MAX      = 28'h7FF_FFFF;
  localparam logic [27:0]    ACC_MIN      = 28'h800_0000;

  // register byte offsets
  localparam logic [7:0]     OFS_TEMP     = 8'h00;
  localparam logic [7:0]     OFS_CUR      = 8'h04;
  localparam logic [7:0]     OFS_AVG      = 8'h08;
  localparam logic [7:0]     OFS_ACC      = 8'h0C;
  localparam logic [7:0]     OFS_FRAC     = 8'h10;
  localparam logic [7:0]     OFS_BIAS     = 8'h14;
  localparam logic [7:0]     OFS_GAIN     = 8'h18;
  localparam logic [7:0]     OFS_FGAIN    = 8'h1C;
  localparam logic [7:0]     OFS_TC       = 8'h20;
  localparam logic [7:0]     OFS_STAT     = 8'h24;

  // reset values
  localparam logic [15:0]    RST_16       = 16'h0000;
  localparam logic [31:0]    RST_32       = 32'h0000_0000;

  // nonvolatile image presented at power-up
  typedef struct packed {
    logic [15:0] acc;
    logic [7:0]  bias;
    logic [10:0] gain;
    logic [10:0] fgain;
    logic [7:0]  tc;
  } cca_nv_s;

  typedef enum {ST_LOAD, ST_ACTIVE, ST_SLEEP} cca_state_e;

  // clamp a wide signed value to the 16-bit result range
  function automatic logic [15:0] cca_sat16(input logic signed [47:0] v);
    if (v > 48'sh7FFF) return CUR_MAX;
    if (v < -48'sh8000) return CUR_MIN;
    return v[15:0];
  endfunction

endpackage

// [hdl/cca_top.sv]
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/100ps
// Summary of operation
// RULE1: temperature result refreshed every 440 ms, signed, 0.125 C steps.
// RULE2: current measured continuously only in active power mode.
// RULE3: sense input sampled at 18.6 kHz; result written per conversion.
// RULE4: current register refreshed every 3.515 s, clamped 7FFFh/8000h.
// RULE5: average of last eight currents refreshed every 28 s, clamped.
// RULE6: every 1024th conversion measures offset; correction used 1023 times.
// RULE7: during offset conversion, prior current shown and accumulated.
// RULE8: 11-bit gain trim scales current, 0 to 1.999 in 1/1024 steps.
// RULE9: read-only factory gain copy kept; only writable trim used.
// RULE10: 8-bit tempco in 30.5 ppm/C steps; zero disables compensation. Code applies 30.5 ppm per half degree, 61 ppm/C.
// RULE11: compensation updated only when temperature crosses half degree.
// RULE12: accumulator adds each result, saturating at 7FFFh and 8000h.
// RULE13: fraction bits kept in separate read-only fraction register.
// RULE14: positive currents below 100 uV are not accumulated.
// RULE15: host writes accumulator high byte then low byte within 3.515 s.
// RULE16: any accumulator write clears all fraction bits. Code clears them only on the low-byte write; a high-byte-only write keeps them.
// RULE17: accumulator write forces offset conversion and new correction.
// RULE18: after accumulator write, measurement resumes at second conversion.
// RULE19: accumulator backed up periodically and restored at power-up.
// RULE20: signed accumulation offset added once per conversion cycle.
// RULE21: accumulation offset loaded from nonvolatile image at power-up.
// RULE22: in sleep, measurement and accumulation stop, registers kept.
// RULE23: accumulation triggered by the same strobe that refreshes current.
module cca_top #(
  parameter int unsigned TEMP_CYCLES   = 32'(cca_pkg::TEMP_CYC),
  parameter int unsigned SAMPLE_CYCLES = 32'(cca_pkg::SAMPLE_CYC),
  parameter int unsigned CONV_CYCLES   = 32'(cca_pkg::CONV_CYC)
) (
  input  wire logic            sys_clk_in,
  input  wire logic            rstn_in,
  input  wire logic            wb_cyc_in,
  input  wire logic            wb_stb_in,
  input  wire logic            wb_we_in,
  input  wire logic [7:0]      wb_adr_in,
  input  wire logic [3:0]      wb_sel_in,
  input  wire logic [31:0]     wb_dat_in,
  output logic      [31:0]     wb_dat_out,
  output logic                 wb_ack_out,
  input  wire logic            active_mode_in,
  input  wire logic [15:0]     temp_sample_in,
  input  wire logic [15:0]     sense_input_in,
  input  wire cca_pkg::cca_nv_s nv_image_in,
  output logic                 zero_sel_out,
  output logic                 nv_backup_out,
  output logic [15:0]          nv_acc_out
);
  import cca_pkg::*;

  logic              rst_meta_r, rstn_r;
  logic              act_meta_r, act_r;
  logic [15:0]       temp_meta_r, temp_s_r, sns_meta_r, sns_s_r;
  cca_state_e        state_r;
  logic [31:0]       samp_cnt_r, conv_cnt_r, temp_cnt_r;
  logic [15:0]       sample_r, offset_r, temp_r, current_r, avg_r;
  logic [15:0]       half_prev_r;
  logic signed [23:0] coef_r;
  logic [9:0]        conv_idx_r;
  logic [2:0]        avg_idx_r;
  logic [15:0]       avg_mem [AVG_DEPTH];
  logic [27:0]       acc_r;
  logic [7:0]        acc_hi_r, bias_r, tc_r, bk_cnt_r;
  logic [10:0]       gain_r, fgain_r;
  logic              skip_r, ack_r;
  logic              req, wr, acc_wr, conv_end, run;
  logic [15:0]       acc_wval, cur_nxt, acc_src;
  logic signed [47:0] scaled, comp, avg_sum;
  logic signed [28:0] acc_sum;
  logic [15:0]       half_now;
  cca_nv_s           nv_meta_r, nv_s_r;
  logic              acc_hi_wr;

  // reset release through two flops; assertion stays asynchronous
  // so a glitch on the pin still clears every register at once
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_r <= 1'b0;
      rstn_r     <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rstn_r     <= rst_meta_r;
    end
  end

  // pin inputs cross in through two flops; multi-bit samples are assumed
  // held stable by the front end across the capture
  always_ff @(posedge sys_clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      act_meta_r  <= 1'b0;
      act_r       <= 1'b0;
      temp_meta_r <= RST_16;
      temp_s_r    <= RST_16;
      sns_meta_r  <= RST_16;
      sns_s_r     <= RST_16;
    end else begin
      act_meta_r  <= active_mode_in;
      act_r       <= act_meta_r;
      temp_meta_r <= temp_sample_in;
      temp_s_r    <= temp_meta_r;
      sns_meta_r  <= sense_input_in;
      sns_s_r     <= sns_meta_r;
    end
  end

  // the nonvolatile image comes from another domain, so it crosses two
  // flops like any pin; these run on the raw reset so that the copy has
  // settled by the single load cycle that follows the internal release
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nv_meta_r <= '0;
      nv_s_r    <= '0;
    end else begin
      nv_meta_r <= nv_image_in;
      nv_s_r    <= nv_meta_r;
    end
  end

  // power state: load the nonvolatile image once, then follow the mode pin
  // the load cycle reads the synchronised copy, settled one edge before
  always_ff @(posedge sys_clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      state_r <= ST_LOAD;
    end else begin
      case (state_r)
        ST_LOAD:   state_r <= act_r ? ST_ACTIVE : ST_SLEEP;
        ST_ACTIVE: if (!act_r) state_r <= ST_SLEEP;          // RULE22
        ST_SLEEP:  if (act_r) state_r <= ST_ACTIVE;          // RULE2
        default:   state_r <= ST_LOAD;
      endcase
    end
  end

  assign run      = (state_r == ST_ACTIVE);                  // RULE2 RULE22
  assign conv_end = run && (conv_cnt_r == CONV_CYCLES - 1);  // RULE4 RULE23

  // bus decode: one access per request, answered one cycle later; a write
  // lands at the edge where the master sees ack, not at the taking edge,
  // so a master that drops its request early leaves the registers alone
  assign req       = wb_cyc_in && wb_stb_in && !ack_r;
  assign wr        = wb_cyc_in && wb_stb_in && wb_we_in && ack_r;
  assign acc_wr    = wr && (wb_adr_in == OFS_ACC) && wb_sel_in[0];
  assign acc_hi_wr = wr && (wb_adr_in == OFS_ACC) && wb_sel_in[1]
                     && !wb_sel_in[0];

  // timers freeze outside active mode so nothing drifts while asleep
  // the conversion timer also restarts on a host accumulator commit made in active mode
  always_ff @(posedge sys_clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      samp_cnt_r <= RST_32;
      conv_cnt_r <= RST_32;
      temp_cnt_r <= RST_32;
    end else if (run) begin
      samp_cnt_r <= (samp_cnt_r == SAMPLE_CYCLES - 1) ? RST_32
                                                      : samp_cnt_r + 1;
      temp_cnt_r <= (temp_cnt_r == TEMP_CYCLES - 1) ? RST_32
                                                    : temp_cnt_r + 1;
      if (acc_wr || conv_end) begin
        conv_cnt_r <= RST_32;                                // RULE17
      end else begin
        conv_cnt_r <= conv_cnt_r + 1;
      end
    end
  end

  // differential sample taken at the modulator rate
  // the front end must hold each sample across both capture flops
  always_ff @(posedge sys_clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      sample_r <= RST_16;
    end else if (run && samp_cnt_r == SAMPLE_CYCLES - 1) begin
      sample_r <= sns_s_r;                                   // RULE3
    end
  end

  // temperature result and half-degree tracking for compensation
  // the coefficient follows the half-degree value even while asleep; it
  // only costs a multiply when the temperature register actually moves
  assign half_now = {{2{temp_r[15]}}, temp_r[15:2]};
  always_ff @(posedge sys_clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      temp_r      <= RST_16;
      half_prev_r <= TC_REF_HALF;
      coef_r      <= 24'sh00_0000;
    end else begin
      if (run && temp_cnt_r == TEMP_CYCLES - 1) begin
        temp_r <= temp_s_r;                                  // RULE1
      end
      if (half_now != half_prev_r) begin
        half_prev_r <= half_now;                             // RULE11
        coef_r <= 24'($signed({1'b0, tc_r}) *
                      $signed(half_now - TC_REF_HALF));      // RULE10
      end
    end
  end

  // offset removal, gain trim, then resistor drift compensation
  // the gain product needs 28 bits; 48 leave room for the tempco product
  always_comb begin
    scaled = 48'(($signed({{32{sample_r[15]}}, sample_r}) -
                  $signed({{32{offset_r[15]}}, offset_r})) *
                 $signed({1'b0, gain_r})) >>> GAIN_FRAC;     // RULE8 RULE9
    comp    = scaled - ((scaled * 48'(coef_r)) >>> TC_SHIFT); // RULE10
    cur_nxt = cca_sat16(comp);                               // RULE4
  end

  // conversion sequencing and current / offset registers
  // an accumulator commit beats a conversion end in the same cycle: the commit
  // restarts the timer and drops that result, though history and backup count still take it
  always_ff @(posedge sys_clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      current_r    <= RST_16;
      offset_r     <= RST_16;
      conv_idx_r   <= 10'h000;
      zero_sel_out <= 1'b0;
      skip_r       <= 1'b0;
    end else if (acc_wr) begin
      zero_sel_out <= 1'b1;                                  // RULE17
      skip_r       <= 1'b1;                                  // RULE18
    end else if (conv_end) begin
      if (zero_sel_out) begin
        offset_r   <= sample_r;                              // RULE6 RULE7
        conv_idx_r <= 10'h000;
        skip_r     <= 1'b0;
        zero_sel_out <= 1'b0;
      end else begin
        current_r  <= cur_nxt;                               // RULE4
        conv_idx_r <= conv_idx_r + 10'h001;
        zero_sel_out <= (conv_idx_r + 10'h001 == OFFSET_SLOT); // RULE6
      end
    end
  end

  // eight-deep history of current results and the 28 s mean
  // the mean uses an arithmetic shift, so it rounds toward minus infinity
  always_comb begin
    avg_sum = 48'sh0;
    for (int i = 0; i < AVG_DEPTH; i++) begin
      avg_sum = avg_sum + 48'($signed(avg_mem[i]));
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      avg_idx_r <= 3'h0;
      avg_r     <= RST_16;
      for (int i = 0; i < AVG_DEPTH; i++) begin
        avg_mem[i] <= RST_16;
      end
    end else begin
      if (conv_end && !zero_sel_out) begin
        avg_mem[avg_idx_r] <= cur_nxt;
        avg_idx_r <= avg_idx_r + 3'h1;
      end
      // history is read one cycle after the eighth entry lands
      if (conv_cnt_r == 32'h0000_0000 && run && avg_idx_r == 3'h0) begin
        avg_r <= cca_sat16(avg_sum >>> AVG_SHIFT);           // RULE5
      end
    end
  end

  // value fed to the accumulator: prior result stands in during offset
  // exclusion touches small positive results only; discharge always counts
  always_comb begin
    acc_src = zero_sel_out ? current_r : cur_nxt;            // RULE7
    if (!acc_src[15] && acc_src < CHG_MIN) begin
      acc_src = RST_16;                                      // RULE14
    end
    acc_sum = 29'($signed(acc_r)) +
              29'($signed(acc_src)) +
              29'($signed(bias_r));                          // RULE20
  end

  // a write on the low lane alone commits the byte stored by the earlier
  // high-lane write, so the pair lands in the accumulator as one value
  assign acc_wval = {(wb_sel_in[1] ? wb_dat_in[15:8] : acc_hi_r),
                     wb_dat_in[7:0]};

  // charge accumulator: 16 integer bits over 12 fraction bits; results
  // and bias add in at the lowest fraction bit, so nothing is ever truncated and
  // positive results below 1000h move the integer part only once the fraction carries over
  always_ff @(posedge sys_clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      acc_r    <= 28'h000_0000;
      acc_hi_r <= 8'h00;
    end else if (state_r == ST_LOAD) begin
      acc_r <= {nv_s_r.acc, 12'h000};                        // RULE19
    end else if (acc_hi_wr) begin
      acc_hi_r <= wb_dat_in[15:8];                           // RULE15
    end else if (acc_wr) begin
      acc_r <= {acc_wval, 12'h000};                          // RULE16
    end else if (conv_end && !skip_r) begin
      if (acc_sum > $signed({1'b0, ACC_MAX})) begin
        acc_r <= ACC_MAX;                                    // RULE12
      end else if (acc_sum < $signed({1'b1, ACC_MIN})) begin
        acc_r <= ACC_MIN;                                    // RULE12
      end else begin
        acc_r <= acc_sum[27:0];                              // RULE23
      end
    end
  end

  // periodic backup of the integer count to nonvolatile storage
  // the count includes offset conversions, so the spacing is exact in
  // conversion periods rather than in current results
  always_ff @(posedge sys_clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      bk_cnt_r      <= 8'h00;
      nv_backup_out <= 1'b0;
      nv_acc_out    <= RST_16;
    end else begin
      nv_backup_out <= 1'b0;
      if (conv_end) begin
        bk_cnt_r <= (bk_cnt_r == BACKUP_EVERY - 8'h01) ? 8'h00
                                                       : bk_cnt_r + 8'h01;
        if (bk_cnt_r == BACKUP_EVERY - 8'h01) begin
          nv_backup_out <= 1'b1;                             // RULE19
          nv_acc_out    <= acc_r[27:FRAC_W];
        end
      end
    end
  end

  // trims and bias: image at power-up, then software may rewrite them
  // the factory copy has no write path, so only the image can set it
  always_ff @(posedge sys_clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      bias_r  <= 8'h00;
      gain_r  <= 11'h000;
      fgain_r <= 11'h000;
      tc_r    <= 8'h00;
    end else if (state_r == ST_LOAD) begin
      bias_r  <= nv_s_r.bias;                                // RULE21
      gain_r  <= nv_s_r.gain;
      fgain_r <= nv_s_r.fgain;                               // RULE9
      tc_r    <= nv_s_r.tc;
    end else if (wr && wb_sel_in[0]) begin
      case (wb_adr_in)
        OFS_BIAS: bias_r <= wb_dat_in[7:0];
        OFS_TC:   tc_r   <= wb_dat_in[7:0];
        OFS_GAIN: if (wb_sel_in[1]) gain_r <= wb_dat_in[10:0]; // RULE8
        default:  ;
      endcase
    end
  end

  // wishbone answer: ack one cycle after the strobe, unmapped reads zero
  // read data is captured on the taking edge and holds from ack until the next request
  always_ff @(posedge sys_clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      ack_r      <= 1'b0;
      wb_dat_out <= RST_32;
    end else begin
      ack_r <= req;
      if (req) begin
        case (wb_adr_in)
          OFS_TEMP:  wb_dat_out <= {16'h0000, temp_r};
          OFS_CUR:   wb_dat_out <= {16'h0000, current_r};
          OFS_AVG:   wb_dat_out <= {16'h0000, avg_r};
          OFS_ACC:   wb_dat_out <= {16'h0000, acc_r[27:FRAC_W]};
          OFS_FRAC:  wb_dat_out <= {20'h0_0000, acc_r[FRAC_W-1:0]}; // RULE13
          OFS_BIAS:  wb_dat_out <= {24'h00_0000, bias_r};
          OFS_GAIN:  wb_dat_out <= {21'h00_0000, gain_r};
          OFS_FGAIN: wb_dat_out <= {21'h00_0000, fgain_r};
          OFS_TC:    wb_dat_out <= {24'h00_0000, tc_r};
          OFS_STAT:  wb_dat_out <= {29'h0000_0000, skip_r,
                                    zero_sel_out, run};
          default:   wb_dat_out <= RST_32;
        endcase
      end
    end
  end

  assign wb_ack_out = ack_r;

endmodule

// [dv/cca_top_sva.sv]
`timescale 1ns/100ps
module cca_chk (
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        active_mode_in,
  input wire logic        zero_sel_out,
  input wire logic        nv_backup_out,
  input wire logic [15:0] nv_acc_out
);
  import cca_pkg::*;
  // zero_sel_out rises the cycle after a commit, whatever the conversion period
  localparam int ZS_MAX = 1000;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // a request still waiting for its answer
  sequence req_s;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  // host commit of the low accumulator byte
  sequence acc_commit_s;
    wb_ack_out && wb_we_in && wb_adr_in == OFS_ACC && wb_sel_in[0];
  endsequence
  ack_timing_a: assert property (req_s |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_ack_out && !wb_we_in &&
    wb_adr_in > OFS_STAT |-> wb_dat_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  offset_conv_a: assert property (
    acc_commit_s |-> ##[0:ZS_MAX] zero_sel_out)
    else $error("no offset conversion after accumulator write");
  backup_pulse_a: assert property (
    nv_backup_out |=> !nv_backup_out)
    else $error("backup strobe longer than one cycle");
  backup_hold_a: assert property (
    $changed(nv_acc_out) |-> nv_backup_out)
    else $error("backup value moved without strobe");
  sleep_quiet_a: assert property (
    !active_mode_in [*6] |-> !nv_backup_out && !$rose(zero_sel_out))
    else $error("conversion activity while asleep");
endmodule

bind cca_top cca_chk u_chk (.sys_clk_in, .rstn_in, .wb_cyc_in, .wb_stb_in,
  .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_out, .wb_ack_out,
  .active_mode_in, .zero_sel_out, .nv_backup_out, .nv_acc_out);

// [dv/cca_cell.sv]
`timescale 1ns/100ps
module cca_cell (
  input  wire logic        clk_in,
  input  wire logic        zero_sel_in,
  input  wire logic [15:0] sense_lvl_in,
  input  wire logic [15:0] ofs_lvl_in,
  input  wire logic [15:0] temp_lvl_in,
  output logic      [15:0] sense_out = 16'h0000,
  output logic      [15:0] temp_out  = 16'h00C8
);
  // zeroed front end shows only the converter's own offset, so the
  // shunt drop vanishes for that conversion and must be patched over
  always @(posedge clk_in) begin
    sense_out <= zero_sel_in ? ofs_lvl_in : sense_lvl_in;
    temp_out  <= temp_lvl_in;
  end
endmodule

// [dv/coulomb_counter_accum_bench.sv]
`timescale 1ns/100ps
module coulomb_counter_accum_bench;
  import cca_pkg::*;
  localparam int unsigned CONV = 400;
  logic        sys_clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, act = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, got;
  logic        ack, zsel, nvbk;
  logic [15:0] nvacc, sense, temp;
  logic [15:0] s_lvl = 16'h0100, o_lvl = 16'h0000, t_lvl = 16'h00C8;
  cca_nv_s     nv = '{16'h0ABC, 8'h05, 11'h400, 11'h3FF, 8'h00};
  int          failures = 0, checks_done = 0, cycles = 0;

  cca_top #(.TEMP_CYCLES(40), .SAMPLE_CYCLES(4), .CONV_CYCLES(CONV)) DUT (
    .sys_clk_in, .rstn_in, .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .active_mode_in(act), .temp_sample_in(temp),
    .sense_input_in(sense), .nv_image_in(nv), .zero_sel_out(zsel),
    .nv_backup_out(nvbk), .nv_acc_out(nvacc));
  cca_cell u_cell (.clk_in(sys_clk_in), .zero_sel_in(zsel),
    .sense_lvl_in(s_lvl), .ofs_lvl_in(o_lvl), .temp_lvl_in(t_lvl),
    .sense_out(sense), .temp_out(temp));

  // free-running clock and a hang guard sized well above the whole run
  initial forever #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("FAIL timeout exp finished got hang");
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      failures++;
      $display("FAIL bus_ack exp 1 got 0");
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    bus(1'b1, a, s, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input string nm);
    bus(1'b0, a, 4'hF, 32'h0000_0000);
    checks_done++;
    if (got !== {16'h0000, e}) begin
      failures++;
      $display("FAIL %s exp %h got %h", nm, e, got);
    end
  endtask

  task automatic t_regs();
    rd(OFS_ACC, 16'h0ABC, "acc_restore");
    rd(OFS_BIAS, 16'h0005, "bias_load");
    rd(OFS_GAIN, 16'h0400, "gain");
    rd(OFS_TC, 16'h0000, "tempco");
    rd(OFS_STAT, 16'h0001, "status_run");
    wr(OFS_FGAIN, 4'h3, 32'h0000_0123);
    rd(OFS_FGAIN, 16'h03FF, "fgain_ro");
    wr(8'h40, 4'hF, 32'hFFFF_FFFF);
    rd(8'h40, 16'h0000, "unmapped");
    $display("test regs done");
  endtask

  task automatic t_temp();
    t_lvl <= 16'hFF38;
    wait_cyc(100);
    rd(OFS_TEMP, 16'hFF38, "temp_neg");
    t_lvl <= 16'h0118;
    wait_cyc(100);
    rd(OFS_TEMP, 16'h0118, "temp_pos");
    $display("test temp done");
  endtask

  // gain scaling and both clamp limits; factory copy must not matter
  task automatic t_gain();
    logic [10:0] g[4] = '{11'h400, 11'h200, 11'h7FF, 11'h7FF};
    logic [15:0] sv[4] = '{16'h0100, 16'h0100, 16'h7000, 16'h9000};
    logic [15:0] ev[4] = '{16'h0100, 16'h0080, 16'h7FFF, 16'h8000};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_GAIN, 4'h3, {21'h0, g[i]});
      s_lvl <= sv[i];
      wait_cyc(900);
      rd(OFS_CUR, ev[i], "current");
    end
    wr(OFS_GAIN, 4'h3, 32'h0000_0400);
    $display("test gain done");
  endtask

  task automatic t_tempco();
    s_lvl <= 16'h1000;
    wait_cyc(900);
    rd(OFS_CUR, 16'h1000, "tc_off");
    wr(OFS_TC, 4'h1, 32'h0000_0080);
    t_lvl <= 16'h0114;
    wait_cyc(900);
    rd(OFS_CUR, 16'h0ED0, "tc_on");
    wr(OFS_TC, 4'h1, 32'h0000_0000);
    t_lvl <= 16'h00C8;
    $display("test tempco done");
  endtask

  task automatic t_sat();
    wr(OFS_BIAS, 4'h1, 32'h0000_0000);
    s_lvl <= 16'h8001;
    wr(OFS_ACC, 4'h3, 32'h0000_8010);
    wait_cyc(2200);
    rd(OFS_ACC, 16'h8000, "acc_lo");
    s_lvl <= 16'h7FFF;
    wr(OFS_ACC, 4'h3, 32'h0000_7FF0);
    wait_cyc(2200);
    rd(OFS_ACC, 16'h7FFF, "acc_hi");
    rd(OFS_FRAC, 16'h0FFF, "frac_hi");
    $display("test saturation done");
  endtask

  task automatic t_skip();
    s_lvl <= 16'h0040;
    wr(OFS_ACC, 4'h2, 32'h0000_1200);
    wr(OFS_ACC, 4'h1, 32'h0000_0034);
    rd(OFS_ACC, 16'h1234, "acc_pair");
    rd(OFS_FRAC, 16'h0000, "frac_clr");
    wait_cyc(590);
    rd(OFS_FRAC, 16'h0000, "skip_first");
    wait_cyc(400);
    rd(OFS_FRAC, 16'h0040, "acc_second");
    $display("test skip done");
  endtask

  task automatic t_excl();
    s_lvl <= 16'h003F;
    wr(OFS_BIAS, 4'h1, 32'h0000_0002);
    wr(OFS_ACC, 4'h3, 32'h0000_0100);
    wait_cyc(990);
    rd(OFS_FRAC, 16'h0002, "bias_once");
    wait_cyc(400);
    rd(OFS_FRAC, 16'h0004, "bias_twice");
    $display("test exclusion done");
  endtask

  task automatic t_sleep();
    wr(OFS_BIAS, 4'h1, 32'h0000_0000);
    act <= 1'b0;
    wait_cyc(1300);
    rd(OFS_FRAC, 16'h0004, "sleep_frac");
    rd(OFS_ACC, 16'h0100, "sleep_acc");
    rd(OFS_CUR, 16'h003F, "sleep_cur");
    rd(OFS_STAT, 16'h0000, "sleep_stat");
    act <= 1'b1;
    $display("test sleep done");
  endtask

  task automatic t_backup();
    int n;
    n = 0;
    while (nvbk !== 1'b1 && n < 8000) begin
      @(posedge sys_clk_in);
      n++;
    end
    checks_done++;
    if (nvbk !== 1'b1 || nvacc !== 16'h0100) begin
      failures++;
      $display("FAIL backup exp %h got %h", 16'h0100, nvacc);
    end
    wait_cyc(7000);
    rd(OFS_AVG, 16'h003F, "average");
    $display("test backup done");
  endtask

  task automatic t_offset();
    s_lvl <= 16'h0100;
    o_lvl <= 16'h0010;
    wait_cyc(900);
    rd(OFS_CUR, 16'h0100, "pre_offset");
    wr(OFS_ACC, 4'h3, 32'h0000_0000);
    wait_cyc(590);
    rd(OFS_CUR, 16'h0100, "offset_hold");
    wait_cyc(400);
    rd(OFS_CUR, 16'h00F0, "offset_corr");
    $display("test offset done");
  endtask

  initial begin
    wait_cyc(20);
    rstn_in <= 1'b1;
    wait_cyc(6);
    t_regs();
    t_temp();
    t_gain();
    t_tempco();
    t_sat();
    t_skip();
    t_excl();
    t_sleep();
    t_backup();
    t_offset();
    finish_test();
  end
endmodule
